// ### core/typec_regs_pkg.sv
// Purpose: constants and types for the port status and command register bank
// Assumes: AXI4-Lite, 32-bit data, byte address is four times the register index
// Notes: reset values of capability words are fixed strap values
package typec_regs_pkg;
   // register indexes; byte address is index times four
   localparam logic [7:0] IDX_LINE_STATUS = 8'h1D;
   localparam logic [7:0] IDX_POWER_STATE = 8'h1E;
   localparam logic [7:0] IDX_FAULT_FLAGS = 8'h1F;
   localparam logic [7:0] IDX_COMMAND_CODE = 8'h23;
   localparam logic [7:0] IDX_CAP_ONE_LOW = 8'h24;
   localparam logic [7:0] IDX_CAP_ONE_HIGH = 8'h25;
   localparam logic [7:0] IDX_CAP_TWO_LOW = 8'h26;
   localparam logic [7:0] IDX_CAP_TWO_HIGH = 8'h27;
   localparam logic [7:0] IDX_INPUT_CAP = 8'h28;
   // control registers that the bank reads, kept locally
   localparam logic [7:0] IDX_ROLE_CFG = 8'h1A;
   localparam logic [7:0] IDX_PORT_CFG = 8'h19;
   localparam logic [7:0] IDX_POWER_CFG = 8'h1C;

   localparam logic [7:0] CMD_NONE = 8'h00;
   localparam logic [7:0] CMD_UNSUPPORTED = 8'h11;
   localparam logic [7:0] CMD_DETECT_OFF = 8'h22;
   localparam logic [7:0] CMD_DETECT_ON = 8'h33;
   localparam logic [7:0] CMD_SINK_OFF = 8'h44;
   localparam logic [7:0] CMD_SINK_ON = 8'h55;
   localparam logic [7:0] CMD_SOURCE_OFF = 8'h66;
   localparam logic [7:0] CMD_SOURCE_SAFE_LEVEL = 8'h77;
   localparam logic [7:0] CMD_SOURCE_HIGH = 8'h88;
   localparam logic [7:0] CMD_TOGGLE = 8'h99;

   localparam logic [1:0] ROLE_RP = 2'h1;
   localparam logic [1:0] ROLE_RD = 2'h2;
   localparam logic [1:0] ROLE_OPEN = 2'h3;

   localparam logic [2:0] SUPPORTED_ROLES = 3'h6;
   localparam logic [1:0] PULLUP_LEVELS_OFFERED = 2'h2;
   localparam logic [1:0] ALARM_RES_25MV = 2'h0;
   localparam logic [7:0] CAP_ONE_LOW = {SUPPORTED_ROLES, 5'h1F};
   localparam logic [7:0] CAP_ONE_HIGH = {6'h1F, PULLUP_LEVELS_OFFERED};
   localparam logic [7:0] CAP_TWO_LOW_BASE = 8'hC1;
   localparam logic [7:0] CAP_TWO_HIGH = 8'h01;
   localparam logic [7:0] INPUT_CAP = 8'h00;
   localparam logic [7:0] ROLE_CFG_RESET = 8'h0A;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int INIT_CYCLES = 16;

   // analog comparator and fault event inputs
   typedef struct packed {
      logic line_one_pull;
      logic [1:0] line_one_level;
      logic [1:0] line_two_level;
      logic supply_seen;
      logic cable_power_seen;
      logic high_voltage_out;
   } sense_t;

   typedef struct packed {
      logic supply_overcurrent;
      logic supply_overvoltage;
      logic cable_power_overcurrent;
      logic auto_discharge_failed;
      logic forced_discharge_failed;
      logic bus_error;
   } fault_evt_t;

   typedef struct packed {
      logic detect_on;
      logic sink_on;
      logic source_on;
      logic source_high;
      logic toggling;
   } path_t;
endpackage : typec_regs_pkg

// ### core/typec_port_status_command_regs.sv
// Purpose: port status, fault latch and command decode bank on AXI4-Lite
// Assumes: comparator and fault inputs synchronous to ref_clk_i
// Notes: one write and one read at a time; reads answer one cycle after acceptance, writes two
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Operation
// - searching bit high while toggling, drops when candidate attach found
// - termination bit: zero presenting Rp, one presenting Rd
// - source encoding: open, Ra, Rd, reserved
// - sink encoding: open, default, 1.5A, 3.0A partner pull-up
// - line status zero when that line role is Ra or open
// - both status fields zero while searching or cable power on line two
// - init busy high during internal init, then cleared
// - high-voltage bit set while sourcing high and supply above safe level, monitor only
// - report sourcing enabled, sinking on, and supply present while detection enabled
// - cable power present bit from fixed threshold comparator
// - registers-defaulted flag resets to one, software clears
// - supply overcurrent, overvoltage, cable overcurrent latched until cleared
// - latch discharge failures in bits 5 and 4, bus errors in lowest bit
// - 22h disables detection, 33h enables detection
// - 44h sink off; 55h sink on, refused with error while sourcing
// - 66h source off and stop reporting supply over faults
// - 77h safe-level source, refused with error while sinking
// - 88h high voltage only if safe sourcing, capable, not sinking
// - 99h starts toggling only if dual-role enabled and lines valid
// - command write-only, 00h no action, 11h unsupported
// - capability roles reads 110, pull-up support reads 10
// - alarm resolution field fixed at 25mV code
// - orientation zero: cable power on line two, monitor line one
// - role settings 01 Rp, 10 Rd, 11 open select encoding
module typec_port_status_command_regs #(
   parameter logic HV_CAPABLE = 1'b1
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [31:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [31:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire typec_regs_pkg::sense_t sense_i,
   input wire typec_regs_pkg::fault_evt_t fault_evt_i,
   input wire logic attach_found_i,
   output typec_regs_pkg::path_t path_o,
   output logic cable_power_line_two_o,
   output logic monitor_line_two_o
);
   import typec_regs_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum {ST_IDLE, ST_RESP} bus_state_t;
   bus_state_t wst_q, wst_d;
   logic aw_got_q, aw_got_d, w_got_q, w_got_d;
   logic [7:0] waddr_q, waddr_d;
   logic [7:0] wdata_q, wdata_d;
   logic wstrb0_q, wstrb0_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [7:0] role_q, role_d;
   logic orient_q, orient_d;
   logic cable_en_q, cable_en_d;
   path_t path_q, path_d;
   logic [7:0] fault_q, fault_d;
   logic [4:0] init_cnt_q, init_cnt_d;
   logic init_busy_q, init_busy_d;
   logic [7:0] line_status_q, line_status_d;
   logic [7:0] power_state_q, power_state_d;
   logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

   function automatic logic mapped(input logic [7:0] idx);
      mapped = (idx == IDX_LINE_STATUS) || (idx == IDX_POWER_STATE) ||
               (idx == IDX_FAULT_FLAGS) || (idx == IDX_COMMAND_CODE) ||
               (idx >= IDX_CAP_ONE_LOW && idx <= IDX_INPUT_CAP) ||
               (idx == IDX_ROLE_CFG) || (idx == IDX_PORT_CFG) ||
               (idx == IDX_POWER_CFG);
   endfunction : mapped

   // decode one line status field from role and comparator level
   function automatic logic [1:0] line_code(input logic [1:0] role, input logic pull,
                                            input logic [1:0] level);
      line_code = 2'h0;
      if (role == ROLE_RP || role == ROLE_RD) begin
         // source view keeps reserved code 11 out of the field
         if (role == ROLE_RP || !pull) begin
            line_code = (level == 2'h3) ? 2'h0 : level;
         end else begin
            line_code = level;
         end
      end
   endfunction : line_code

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic wr_fire;
   logic [7:0] cmd;
   always_comb begin
      wst_d = wst_q;
      aw_got_d = aw_got_q;
      w_got_d = w_got_q;
      waddr_d = waddr_q;
      wdata_d = wdata_q;
      wstrb0_d = wstrb0_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      role_d = role_q;
      orient_d = orient_q;
      cable_en_d = cable_en_q;
      path_d = path_q;
      fault_d = fault_q;
      init_cnt_d = init_cnt_q;
      init_busy_d = init_busy_q;
      wr_fire = 1'b0;
      cmd = CMD_NONE;

      if (init_busy_q) begin
         init_cnt_d = init_cnt_q + 5'h01;
         if (init_cnt_q == 5'(INIT_CYCLES - 1)) begin
            init_busy_d = 1'b0;
         end
      end

      unique case (wst_q)
         ST_IDLE: begin
            if (s_axi_awvalid_i && !aw_got_q) begin
               aw_got_d = 1'b1;
               waddr_d = s_axi_awaddr_i[9:2];
            end
            if (s_axi_wvalid_i && !w_got_q) begin
               w_got_d = 1'b1;
               wdata_d = s_axi_wdata_i[7:0];
               wstrb0_d = s_axi_wstrb_i[0];
            end
            if (aw_got_d && w_got_d) begin
               wst_d = ST_RESP;
            end
         end
         ST_RESP: begin
            if (!bvalid_q) begin
               wr_fire = 1'b1;
               bvalid_d = 1'b1;
               bresp_d = mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_i) begin
               bvalid_d = 1'b0;
               aw_got_d = 1'b0;
               w_got_d = 1'b0;
               wst_d = ST_IDLE;
            end
         end
      endcase

      // hardware fault events; set wins over a same-cycle software clear
      if (wr_fire && wstrb0_q && waddr_q == IDX_FAULT_FLAGS) begin
         fault_d = fault_q & ~wdata_q;
      end
      if (wr_fire && wstrb0_q) begin
         if (waddr_q == IDX_ROLE_CFG) role_d = wdata_q;
         if (waddr_q == IDX_PORT_CFG) orient_d = wdata_q[0];
         if (waddr_q == IDX_POWER_CFG) cable_en_d = wdata_q[0];
         if (waddr_q == IDX_COMMAND_CODE) cmd = wdata_q;
      end
      unique case (cmd)
         CMD_DETECT_OFF: path_d.detect_on = 1'b0;
         CMD_DETECT_ON: path_d.detect_on = 1'b1;
         CMD_SINK_OFF: path_d.sink_on = 1'b0;
         CMD_SINK_ON: begin
            if (path_q.source_on) fault_d[0] = 1'b1;
            else begin
               path_d.sink_on = 1'b1;
               path_d.detect_on = 1'b1;
            end
         end
         CMD_SOURCE_OFF: begin
            path_d.source_on = 1'b0;
            path_d.source_high = 1'b0;
         end
         CMD_SOURCE_SAFE_LEVEL: begin
            if (path_q.sink_on) fault_d[0] = 1'b1;
            else begin
               path_d.source_on = 1'b1;
               path_d.source_high = 1'b0;
               path_d.detect_on = 1'b1;
            end
         end
         CMD_SOURCE_HIGH: begin
            if (path_q.sink_on || !HV_CAPABLE || !path_q.source_on || path_q.source_high) begin
               fault_d[0] = path_q.sink_on || !HV_CAPABLE || !path_q.source_on;
            end else begin
               path_d.source_high = 1'b1;
            end
         end
         CMD_TOGGLE: begin
            if (role_q[6] && role_q[1:0] == role_q[3:2] &&
                (role_q[1:0] == ROLE_RP || role_q[1:0] == ROLE_RD)) begin
               path_d.toggling = 1'b1;
            end
         end
         default: begin
         end
      endcase
      if (attach_found_i) path_d.toggling = 1'b0;

      if (fault_evt_i.supply_overcurrent && path_q.source_on) fault_d[3] = 1'b1;
      if (fault_evt_i.supply_overvoltage && path_q.source_on) fault_d[2] = 1'b1;
      if (fault_evt_i.cable_power_overcurrent) fault_d[1] = 1'b1;
      if (fault_evt_i.auto_discharge_failed) fault_d[5] = 1'b1;
      if (fault_evt_i.forced_discharge_failed) fault_d[4] = 1'b1;
      if (fault_evt_i.bus_error) fault_d[0] = 1'b1;
      fault_d[6] = 1'b0;

      // read channel
      if (rvalid_q) begin
         if (s_axi_rready_i) rvalid_d = 1'b0;
      end else if (s_axi_arvalid_i) begin
         rvalid_d = 1'b1;
         rresp_d = mapped(s_axi_araddr_i[9:2]) ? RESP_OKAY : RESP_SLVERR;
         rdata_d = 32'h0000_0000;
         unique case (s_axi_araddr_i[9:2])
            IDX_LINE_STATUS: rdata_d[7:0] = line_status_q;
            IDX_POWER_STATE: rdata_d[7:0] = power_state_q;
            IDX_FAULT_FLAGS: rdata_d[7:0] = fault_q;
            IDX_CAP_ONE_LOW: rdata_d[7:0] = CAP_ONE_LOW;
            IDX_CAP_ONE_HIGH: rdata_d[7:0] = CAP_ONE_HIGH;
            IDX_CAP_TWO_LOW: rdata_d[7:0] = CAP_TWO_LOW_BASE | {2'h0, ALARM_RES_25MV, 4'h0};
            IDX_CAP_TWO_HIGH: rdata_d[7:0] = CAP_TWO_HIGH;
            IDX_INPUT_CAP: rdata_d[7:0] = INPUT_CAP;
            IDX_ROLE_CFG: rdata_d[7:0] = role_q;
            IDX_PORT_CFG: rdata_d[7:0] = {7'h00, orient_q};
            IDX_POWER_CFG: rdata_d[7:0] = {7'h00, cable_en_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
      // ready lines built from the next state so each leaves on a flop
      awready_d = (wst_d == ST_IDLE) && !aw_got_d;
      wready_d = (wst_d == ST_IDLE) && !w_got_d;
      arready_d = !rvalid_d;
   end

   // status words rebuilt every cycle
   always_comb begin
      line_status_d = 8'h00;
      line_status_d[5] = path_q.toggling;
      line_status_d[4] = sense_i.line_one_pull;
      if (!(path_q.toggling || (cable_en_q && !orient_q))) begin
         line_status_d[1:0] = line_code(role_q[1:0], sense_i.line_one_pull,
                                        sense_i.line_one_level);
         line_status_d[3:2] = line_code(role_q[3:2], sense_i.line_one_pull,
                                        sense_i.line_two_level);
      end
      power_state_d = {1'b0, init_busy_q,
                       path_q.source_high && sense_i.high_voltage_out,
                       path_q.source_on, path_q.detect_on,
                       sense_i.supply_seen && path_q.detect_on,
                       sense_i.cable_power_seen,
                       path_q.sink_on};
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wst_q <= ST_IDLE;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         waddr_q <= 8'h00;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
         role_q <= ROLE_CFG_RESET;
         orient_q <= 1'b0;
         cable_en_q <= 1'b0;
         path_q <= '{detect_on: 1'b1, default: 1'b0};
         fault_q <= 8'h80;
         init_cnt_q <= 5'h00;
         init_busy_q <= 1'b1;
         line_status_q <= 8'h00;
         power_state_q <= 8'h48;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         arready_q <= 1'b1;
      end else begin
         wst_q <= wst_d;
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
         wstrb0_q <= wstrb0_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         role_q <= role_d;
         orient_q <= orient_d;
         cable_en_q <= cable_en_d;
         path_q <= path_d;
         fault_q <= fault_d;
         init_cnt_q <= init_cnt_d;
         init_busy_q <= init_busy_d;
         line_status_q <= line_status_d;
         power_state_q <= power_state_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         arready_q <= arready_d;
      end
   end

   // orientation steering of cable power and messaging monitor
   logic cable_two_q, mon_two_q;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cable_two_q <= 1'b0;
         mon_two_q <= 1'b0;
      end else begin
         cable_two_q <= cable_en_q && !orient_q;
         mon_two_q <= orient_q;
      end
   end

   assign s_axi_awready_o = awready_q;
   assign s_axi_wready_o = wready_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_arready_o = arready_q;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;
   assign path_o = path_q;
   assign cable_power_line_two_o = cable_two_q;
   assign monitor_line_two_o = mon_two_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   chk_sink_refused: assert property (wr_fire && cmd == CMD_SINK_ON && path_q.source_on |=>
      !path_q.sink_on && fault_q[0]) else $error("sink accepted while sourcing");
   chk_source_refused: assert property (wr_fire && cmd == CMD_SOURCE_SAFE_LEVEL && path_q.sink_on
      |=> !path_q.source_on && fault_q[0]) else $error("source accepted while sinking");
   chk_high_needs_safe: assert property ($rose(path_q.source_high) |-> $past(path_q.source_on))
      else $error("high voltage without safe level");
   chk_source_off: assert property (wr_fire && cmd == CMD_SOURCE_OFF |=>
      !path_q.source_on && !path_q.source_high) else $error("source off ignored");
   chk_detect_cmds: assert property (wr_fire && cmd == CMD_DETECT_OFF |=> !path_q.detect_on ##1
      !power_state_q[2]) else $error("detect off ignored");
   chk_fault_sticky: assert property (fault_q[3] && !(wr_fire && wstrb0_q &&
      waddr_q == IDX_FAULT_FLAGS) |=> fault_q[3]) else $error("overcurrent flag dropped");
   chk_line_forced: assert property (path_q.toggling || (cable_en_q && !orient_q) |=>
      line_status_q[3:0] == 4'h0) else $error("line status not forced");
   chk_init_done: assert property ($fell(rst_i) |-> init_busy_q [*8])
      else $error("init busy too short");
   chk_toggle_rule: assert property ($rose(path_q.toggling) |-> $past(role_q[6]))
      else $error("toggle without dual role");
   chk_bus_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read not answered");
   cov_sink_on: cover property (wr_fire && cmd == CMD_SINK_ON ##1 path_q.sink_on);
   cov_high: cover property (path_q.source_on ##[1:20] path_q.source_high);
   cov_attach: cover property (path_q.toggling ##1 !path_q.toggling);
endmodule : typec_port_status_command_regs

// ### bench/sense_model.sv
// Purpose: far-side model of the analog comparators and power path
// Assumes: bench sets line levels, pull and supply; path comes from the bank
// Notes: high-voltage sense lags the commanded path by one cycle
`timescale 1ns/1ps
module sense_model (
   input wire logic ref_clk_i,
   input wire logic pull_i,
   input wire logic [1:0] lvl_one_i,
   input wire logic [1:0] lvl_two_i,
   input wire logic ext_supply_i,
   input wire logic cable_power_i,
   input wire typec_regs_pkg::path_t path_i,
   output typec_regs_pkg::sense_t sense_o
);
   import typec_regs_pkg::*;
   logic hv_q = 1'b0;
   // supply rail only rises above safe level once high sourcing is on
   always_ff @(posedge ref_clk_i) begin
      hv_q <= path_i.source_high;
   end
   assign sense_o = {pull_i, lvl_one_i, lvl_two_i, ext_supply_i | path_i.source_on,
      cable_power_i, hv_q};
endmodule : sense_model

// ### bench/typec_port_status_command_regs_tb_top.sv
// Purpose: self-checking bench for the port status and command bank
// Assumes: single 125 MHz clock, synchronous active-high reset
// Notes: write strobes tied to all ones, only byte lane zero matters
`timescale 1ns/1ps
module typec_port_status_command_regs_tb_top;
   import typec_regs_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, attach = 1'b0;
   logic awrdy, wrdy, bv, arrdy, rv, cp2, mon2;
   logic [1:0] bresp, rresp, wresp;
   logic pull = 1'b0, ext = 1'b0, vcp = 1'b0;
   logic [1:0] l1 = 2'h0, l2 = 2'h0;
   fault_evt_t fev = '0;
   sense_t sense;
   path_t path;
   int failures = 0, n_compared = 0, cyc = 0;

   initial forever #4 clk = ~clk;

   typec_port_status_command_regs i_typec_port_status_command_regs (.ref_clk_i(clk),
      .rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(rry), .sense_i(sense), .fault_evt_i(fev), .attach_found_i(attach),
      .path_o(path), .cable_power_line_two_o(cp2), .monitor_line_two_o(mon2));
   sense_model i_sense_model (.ref_clk_i(clk), .pull_i(pull), .lvl_one_i(l1),
      .lvl_two_i(l2), .ext_supply_i(ext), .cable_power_i(vcp), .path_i(path),
      .sense_o(sense));

   task final_report;
      if (failures == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         final_report();
      end
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task wr(input logic [7:0] i, input logic [7:0] d);
      logic a, w, b;
      a = 1'b0;
      w = 1'b0;
      @(posedge clk);
      awaddr <= {22'h0, i, 2'b00};
      wdata <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      while (!(a && w)) begin
         @(negedge clk);
         a = a | awrdy;
         w = w | wrdy;
         @(posedge clk);
         if (a) awv <= 1'b0;
         if (w) wv <= 1'b0;
      end
      do begin
         @(negedge clk);
         b = bv;
         wresp = bresp;
         @(posedge clk);
      end while (!b);
      bry <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
      logic a;
      @(posedge clk);
      araddr <= {22'h0, i, 2'b00};
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(negedge clk);
         a = arrdy;
         @(posedge clk);
      end while (!a);
      arv <= 1'b0;
      do begin
         @(negedge clk);
         a = rv;
         d = rdata;
         r = rresp;
         @(posedge clk);
      end while (!a);
      rry <= 1'b0;
   endtask : rd

   task rc(input string n, input logic [7:0] i, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(i, d, r);
      chk(n, e, d);
      chk({n, "_resp"}, {30'h0, RESP_OKAY}, {30'h0, r});
   endtask : rc

   task t_reset_vals;
      rc("power_state", IDX_POWER_STATE, 32'h48);
      repeat (20) @(posedge clk);
      rc("power_state", IDX_POWER_STATE, 32'h08);
      rc("fault_flags", IDX_FAULT_FLAGS, 32'h80);
      wr(IDX_FAULT_FLAGS, 8'hFF);
      chk("fault_bresp", {30'h0, RESP_OKAY}, {30'h0, wresp});
      rc("fault_flags", IDX_FAULT_FLAGS, 32'h00);
   endtask : t_reset_vals

   task t_caps;
      logic [31:0] d;
      logic [1:0] r;
      rd(IDX_CAP_ONE_LOW, d, r);
      chk("supported_roles", 32'h6, {29'h0, d[7:5]});
      rd(IDX_CAP_ONE_HIGH, d, r);
      chk("pullup_levels_offered", 32'h2, {30'h0, d[1:0]});
      rd(IDX_CAP_TWO_LOW, d, r);
      chk("alarm_resolution", 32'h0, {30'h0, d[5:4]});
      rd(8'h30, d, r);
      chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk("unmapped_data", 32'h0, d);
      wr(8'h30, 8'h00);
      chk("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, wresp});
   endtask : t_caps

   task t_cmds;
      // each row: command, path after it, interface error expected
      logic [13:0] rows [15] = '{{8'h55, 5'b11000, 1'b0}, {8'h22, 5'b01000, 1'b0},
         {8'h33, 5'b11000, 1'b0}, {8'h77, 5'b11000, 1'b1}, {8'h88, 5'b11000, 1'b1},
         {8'h44, 5'b10000, 1'b0}, {8'h88, 5'b10000, 1'b1}, {8'h77, 5'b10100, 1'b0},
         {8'h55, 5'b10100, 1'b1}, {8'h88, 5'b10110, 1'b0}, {8'h00, 5'b10110, 1'b0},
         {8'h77, 5'b10100, 1'b0}, {8'h88, 5'b10110, 1'b0}, {8'h66, 5'b10000, 1'b0},
         {8'h11, 5'b10000, 1'b0}};
      logic [4:0] p;
      for (int k = 0; k < 15; k++) begin
         p = rows[k][5:1];
         wr(IDX_COMMAND_CODE, rows[k][13:6]);
         repeat (3) @(posedge clk);
         chk("path", {27'h0, p}, {27'h0, path});
         rc("power_state", IDX_POWER_STATE, {24'h0, 2'b00, p[1], p[2], p[4],
            p[4] & p[2], 1'b0, p[3]});
         rc("fault_flags", IDX_FAULT_FLAGS, {31'h0, rows[k][0]});
         if (rows[k][0]) wr(IDX_FAULT_FLAGS, 8'h01);
      end
   endtask : t_cmds

   task pulse(input logic [5:0] v);
      @(posedge clk);
      fev <= v;
      @(posedge clk);
      fev <= '0;
   endtask : pulse

   task t_faults;
      wr(IDX_COMMAND_CODE, CMD_SOURCE_SAFE_LEVEL);
      pulse(6'h3F);
      rc("fault_flags", IDX_FAULT_FLAGS, 32'h3F);
      rc("fault_flags", IDX_FAULT_FLAGS, 32'h3F);
      wr(IDX_FAULT_FLAGS, 8'h3F);
      rc("fault_flags", IDX_FAULT_FLAGS, 32'h00);
      wr(IDX_COMMAND_CODE, CMD_SOURCE_OFF);
      pulse(6'h30);
      rc("fault_flags", IDX_FAULT_FLAGS, 32'h00);
   endtask : t_faults

   task t_lines;
      @(posedge clk);
      pull <= 1'b1;
      l1 <= 2'h3;
      l2 <= 2'h2;
      rc("line_status", IDX_LINE_STATUS, 32'h1B);
      wr(IDX_ROLE_CFG, 8'h0B);
      rc("line_status", IDX_LINE_STATUS, 32'h18);
      pull <= 1'b0;
      l2 <= 2'h1;
      wr(IDX_ROLE_CFG, 8'h05);
      rc("line_status", IDX_LINE_STATUS, 32'h04);
      wr(IDX_POWER_CFG, 8'h01);
      rc("line_status", IDX_LINE_STATUS, 32'h00);
      chk("cable_power_line_two", 32'h1, {31'h0, cp2});
      wr(IDX_PORT_CFG, 8'h01);
      rc("line_status", IDX_LINE_STATUS, 32'h04);
      chk("orientation_outs", 32'h1, {30'h0, cp2, mon2});
      wr(IDX_POWER_CFG, 8'h00);
      wr(IDX_PORT_CFG, 8'h00);
   endtask : t_lines

   task t_toggle;
      l1 <= 2'h2;
      l2 <= 2'h2;
      wr(IDX_ROLE_CFG, 8'h45);
      wr(IDX_COMMAND_CODE, CMD_TOGGLE);
      repeat (3) @(posedge clk);
      chk("path", 32'h11, {27'h0, path});
      rc("line_status", IDX_LINE_STATUS, 32'h20);
      attach <= 1'b1;
      @(posedge clk);
      attach <= 1'b0;
      repeat (3) @(posedge clk);
      chk("path", 32'h10, {27'h0, path});
      rc("line_status", IDX_LINE_STATUS, 32'h0A);
      wr(IDX_ROLE_CFG, 8'h05);
      wr(IDX_COMMAND_CODE, CMD_TOGGLE);
      rc("fault_flags", IDX_FAULT_FLAGS, 32'h00);
      chk("path", 32'h10, {27'h0, path});
      wr(IDX_FAULT_FLAGS, 8'h01);
      ext <= 1'b1;
      vcp <= 1'b1;
      rc("power_state", IDX_POWER_STATE, 32'h0E);
   endtask : t_toggle

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset_vals();
      t_caps();
      t_cmds();
      t_faults();
      t_lines();
      t_toggle();
      final_report();
   end
endmodule : typec_port_status_command_regs_tb_top
